// *** core/psf_defines.svh ***
// constants for the profiling sampler feature register and its access checks
`ifndef PSF_DEFINES_SVH
`define PSF_DEFINES_SVH

`define PSF_COUNTER_WIDTH_LSB     16
`define PSF_COUNTER_WIDTH_CODE    4'h2
`define PSF_RECORD_SIZE_LSB       12
`define PSF_RECORD_SIZE_CODE      4'h6
`define PSF_INTERVAL_HINT_LSB     8
`define PSF_INTERVAL_HINT_CODE    4'h4
`define PSF_RANDOM_STYLE_BIT      5
`define PSF_RANDOM_STYLE_VAL      1'h0
`define PSF_LOAD_SOURCE_BIT       4
`define PSF_LOAD_SOURCE_VAL       1'h1
`define PSF_GRANULARITY_BIT       3
`define PSF_GRANULARITY_VAL       1'h0
`define PSF_LATENCY_FILT_BIT      2
`define PSF_OPTYPE_FILT_BIT       1
`define PSF_EVENT_FILT_BIT        0

`define PSF_ENC_OP0               2'h3
`define PSF_ENC_OP1               3'h0
`define PSF_ENC_CRN               4'h9
`define PSF_ENC_CRM               4'h9
`define PSF_ENC_OP2               3'h7

`define PSF_SYNDROME_CLASS        6'h18
`define PSF_OWN_SECURE            2'h1
`define PSF_OWN_NONSECURE         2'h3

`endif

// *** core/psf_pkg.sv ***
// types for the profiling sampler feature register
package psf_pkg;

  typedef enum logic [1:0] {
    PSF_EL_USER    = 2'h0,
    PSF_EL_KERNEL  = 2'h1,
    PSF_EL_HYP     = 2'h2,
    PSF_EL_MONITOR = 2'h3
  } psf_el_t;

  typedef enum logic [1:0] {
    PSF_RES_DATA  = 2'h0,
    PSF_RES_UNDEF = 2'h1,
    PSF_RES_TRAP  = 2'h2
  } psf_res_t;

endpackage : psf_pkg

// *** core/psf_feature_reg.sv ***
// profiling sampler feature register with its read access checks
// Notes on behaviour
// - read-only 64-bit feature register, fixed values
// - bits 19:16 code 12-bit saturating counters
// - bits 15:12 read 0110, 64-byte records
// - bits 11:8 recommend minimum interval 1,024
// - bit 5 zero, random added at start
// - bit 4 one, bit 3 zero
// - bit 2 reads one, latency filter
// - bit 1 reads one, op-type filter
// - bit 0 reads one, event filter
// - decode op0 11, op1 0, 1001, 1001, 111
// - user-level read is undefined
// - kernel fine-grain read trap to hypervisor
// - kernel hypervisor profiling trap to hypervisor
// - secure ownership not 01 traps to monitor
// - non-secure ownership not 11 traps monitor
// - hypervisor level applies only ownership checks
// - monitor level always returns the value
`timescale 1ns/1ps
`include "psf_defines.svh"

module psf_feature_reg
  import psf_pkg::*;
(
  input  wire logic        i_clk,                    // core clock, 200 MHz
  input  wire logic        i_rst,                    // synchronous reset, active high
  input  wire logic        i_req,                    // system-register access request pulse
  input  wire logic        i_write,                  // access is a write
  input  wire logic [1:0]  i_op0,                    // encoding op0
  input  wire logic [2:0]  i_op1,                    // encoding op1
  input  wire logic [3:0]  i_crn,                    // encoding CRn
  input  wire logic [3:0]  i_crm,                    // encoding CRm
  input  wire logic [2:0]  i_op2,                    // encoding op2
  input  wire logic [1:0]  i_el,                     // current exception level
  input  wire logic        i_hyp_enabled,            // hypervisor level enabled
  input  wire logic        i_fine_grain_trap_enable, // monitor fine-grained trap enable
  input  wire logic        i_hyp_fine_read_trap_bit, // hypervisor fine read trap for this reg
  input  wire logic        i_hyp_profiling_trap,     // hypervisor profiling trap
  input  wire logic [1:0]  i_monitor_buffer_ownership, // monitor buffer ownership field
  input  wire logic        i_nonsecure_state_flag,   // non-secure state
  output logic             o_hit,                    // answer valid, one cycle
  output logic [63:0]      o_rdata,                  // read data
  output logic             o_undef,                  // undefined instruction
  output logic             o_trap,                   // trap taken
  output logic [1:0]       o_trap_el,                // target level of trap
  output logic [5:0]       o_trap_class              // syndrome class
);

  logic [63:0] feature_value;
  logic        sel;
  psf_res_t    res;
  psf_el_t     tgt;

  // fixed value built from constants; no storage, so writes cannot alter it
  always_comb begin
    feature_value = 64'h0;
    feature_value[`PSF_COUNTER_WIDTH_LSB +: 4] = `PSF_COUNTER_WIDTH_CODE;
    feature_value[`PSF_RECORD_SIZE_LSB +: 4]   = `PSF_RECORD_SIZE_CODE;
    feature_value[`PSF_INTERVAL_HINT_LSB +: 4] = `PSF_INTERVAL_HINT_CODE;
    feature_value[`PSF_RANDOM_STYLE_BIT]       = `PSF_RANDOM_STYLE_VAL;
    feature_value[`PSF_LOAD_SOURCE_BIT]        = `PSF_LOAD_SOURCE_VAL;
    feature_value[`PSF_GRANULARITY_BIT]        = `PSF_GRANULARITY_VAL;
    feature_value[`PSF_LATENCY_FILT_BIT]       = 1'h1;
    feature_value[`PSF_OPTYPE_FILT_BIT]        = 1'h1;
    feature_value[`PSF_EVENT_FILT_BIT]         = 1'h1;
  end

  // a write with this encoding gets no answer at all, so it cannot alter the value
  assign sel = i_req && !i_write && i_op0 == `PSF_ENC_OP0 && i_op1 == `PSF_ENC_OP1
               && i_crn == `PSF_ENC_CRN && i_crm == `PSF_ENC_CRM
               && i_op2 == `PSF_ENC_OP2;

  // priority follows the access check order; the ownership check is shared
  always_comb begin
    logic own_bad;
    own_bad = (!i_nonsecure_state_flag && i_monitor_buffer_ownership != `PSF_OWN_SECURE)
           || (i_nonsecure_state_flag && i_monitor_buffer_ownership != `PSF_OWN_NONSECURE);
    res = PSF_RES_DATA;
    tgt = PSF_EL_USER;
    case (psf_el_t'(i_el))
      PSF_EL_USER: begin
        res = PSF_RES_UNDEF;
      end
      PSF_EL_KERNEL: begin
        if (i_hyp_enabled && i_fine_grain_trap_enable && i_hyp_fine_read_trap_bit) begin
          res = PSF_RES_TRAP;
          tgt = PSF_EL_HYP;
        end else if (i_hyp_enabled && i_hyp_profiling_trap) begin
          res = PSF_RES_TRAP;
          tgt = PSF_EL_HYP;
        // hypervisor traps take precedence over the ownership check
        end else if (own_bad) begin
          res = PSF_RES_TRAP;
          tgt = PSF_EL_MONITOR;
        end
      end
      PSF_EL_HYP: begin
        if (own_bad) begin
          res = PSF_RES_TRAP;
          tgt = PSF_EL_MONITOR;
        end
      end
      PSF_EL_MONITOR: begin
        res = PSF_RES_DATA;
      end
      default: begin
        res = PSF_RES_UNDEF;
      end
    endcase
  end

  logic        hit_r, hit_nxt;
  logic [63:0] rdata_r, rdata_nxt;
  logic        undef_r, undef_nxt;
  logic        trap_r, trap_nxt;
  logic [1:0]  trap_el_r, trap_el_nxt;
  logic [5:0]  trap_class_r, trap_class_nxt;

  always_comb begin
    hit_nxt        = sel;
    rdata_nxt      = 64'h0;
    undef_nxt      = 1'b0;
    trap_nxt       = 1'b0;
    trap_el_nxt    = 2'h0;
    trap_class_nxt = 6'h0;
    if (sel) begin
      case (res)
        PSF_RES_DATA: begin
          rdata_nxt = feature_value;
        end
        PSF_RES_UNDEF: begin
          undef_nxt = 1'b1;
        end
        PSF_RES_TRAP: begin
          trap_nxt       = 1'b1;
          trap_el_nxt    = tgt;
          trap_class_nxt = `PSF_SYNDROME_CLASS;
        end
        default: begin
          undef_nxt = 1'b1;
        end
      endcase
    end
  end

  // answers are registered so every output comes straight from a flip-flop
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      hit_r        <= 1'b0;
      rdata_r      <= 64'h0;
      undef_r      <= 1'b0;
      trap_r       <= 1'b0;
      trap_el_r    <= 2'h0;
      trap_class_r <= 6'h0;
    end else begin
      hit_r        <= hit_nxt;
      rdata_r      <= rdata_nxt;
      undef_r      <= undef_nxt;
      trap_r       <= trap_nxt;
      trap_el_r    <= trap_el_nxt;
      trap_class_r <= trap_class_nxt;
    end
  end

  assign o_hit        = hit_r;
  assign o_rdata      = rdata_r;
  assign o_undef      = undef_r;
  assign o_trap       = trap_r;
  assign o_trap_el    = trap_el_r;
  assign o_trap_class = trap_class_r;

  // checks on the answer, one cycle after the request is taken
  property p_value;
    @(posedge i_clk) disable iff (i_rst)
      o_hit && !o_undef && !o_trap |-> o_rdata == 64'h0000_0000_0002_6417;
  endproperty
  a_value: assert property (p_value) else $error("feature value wrong");

  property p_decode;
    @(posedge i_clk) disable iff (i_rst)
      i_req && !i_write && {i_op0, i_op1, i_crn, i_crm, i_op2} != 16'hC4CF |=> !o_hit;
  endproperty
  a_decode: assert property (p_decode) else $error("wrong encoding answered");

  property p_user;
    @(posedge i_clk) disable iff (i_rst)
      sel && i_el == 2'h0 |=> o_undef && !o_trap && o_rdata == 64'h0;
  endproperty
  a_user: assert property (p_user) else $error("user read not undefined");

  property p_fine;
    @(posedge i_clk) disable iff (i_rst)
      sel && i_el == 2'h1 && i_hyp_enabled && i_fine_grain_trap_enable
      && i_hyp_fine_read_trap_bit |=> o_trap && o_trap_el == 2'h2 && o_trap_class == 6'h18;
  endproperty
  a_fine: assert property (p_fine) else $error("fine trap missing");

  property p_prof;
    @(posedge i_clk) disable iff (i_rst)
      sel && i_el == 2'h1 && i_hyp_enabled && i_hyp_profiling_trap
      |=> o_trap && o_trap_el == 2'h2;
  endproperty
  a_prof: assert property (p_prof) else $error("profiling trap missing");

  property p_sec;
    @(posedge i_clk) disable iff (i_rst)
      sel && i_el == 2'h2 && !i_nonsecure_state_flag && i_monitor_buffer_ownership != 2'h1
      |=> o_trap && o_trap_el == 2'h3 && o_trap_class == 6'h18;
  endproperty
  a_sec: assert property (p_sec) else $error("secure ownership trap missing");

  property p_nsec;
    @(posedge i_clk) disable iff (i_rst)
      sel && i_el[1] != i_el[0] && i_nonsecure_state_flag && i_monitor_buffer_ownership != 2'h3
      && !(i_el == 2'h1 && i_hyp_enabled) |=> o_trap && o_trap_el == 2'h3;
  endproperty
  a_nsec: assert property (p_nsec) else $error("non-secure ownership trap missing");

  property p_hyp_ok;
    @(posedge i_clk) disable iff (i_rst)
      sel && i_el == 2'h2 && i_monitor_buffer_ownership == {i_nonsecure_state_flag, 1'h1}
      |=> o_hit && !o_trap && !o_undef;
  endproperty
  a_hyp_ok: assert property (p_hyp_ok) else $error("hypervisor read refused");

  property p_mon;
    @(posedge i_clk) disable iff (i_rst)
      sel && i_el == 2'h3 |=> !o_trap && !o_undef && o_rdata[2:0] == 3'h7;
  endproperty
  a_mon: assert property (p_mon) else $error("monitor read refused");

  property p_write;
    @(posedge i_clk) disable iff (i_rst)
      i_req && i_write |=> !o_hit;
  endproperty
  a_write: assert property (p_write) else $error("write answered");

  // every decoded read is answered exactly one cycle later
  property p_answer;
    @(posedge i_clk) disable iff (i_rst)
      i_req && !i_write && {i_op0, i_op1, i_crn, i_crm, i_op2} == 16'hC4CF |=> o_hit;
  endproperty
  a_answer: assert property (p_answer) else $error("decoded read not answered");

  // with no answer every output rests at zero
  property p_quiet;
    @(posedge i_clk) disable iff (i_rst)
      !o_hit |-> o_rdata == 64'h0 && !o_undef && !o_trap && o_trap_el == 2'h0
      && o_trap_class == 6'h0;
  endproperty
  a_quiet: assert property (p_quiet) else $error("outputs active without an answer");

  // an answer carries one outcome only; a refused read returns no data
  property p_one_kind;
    @(posedge i_clk) disable iff (i_rst)
      o_hit && (o_undef || o_trap) |-> o_undef != o_trap && o_rdata == 64'h0;
  endproperty
  a_one_kind: assert property (p_one_kind) else $error("answer has mixed outcome");

  // a trap always names a higher level and the system access class
  property p_trap_code;
    @(posedge i_clk) disable iff (i_rst)
      o_trap |-> o_hit && o_trap_class == 6'h18 && o_trap_el[1];
  endproperty
  a_trap_code: assert property (p_trap_code) else $error("trap code wrong");

  // kernel level without a hypervisor still meets the ownership check
  property p_kern_sec;
    @(posedge i_clk) disable iff (i_rst)
      sel && i_el == 2'h1 && !i_hyp_enabled && !i_nonsecure_state_flag
      && i_monitor_buffer_ownership != 2'h1 |=> o_trap && o_trap_el == 2'h3;
  endproperty
  a_kern_sec: assert property (p_kern_sec) else $error("kernel ownership trap missing");

  // kernel read with no trap condition returns the value
  property p_kern_ok;
    @(posedge i_clk) disable iff (i_rst)
      sel && i_el == 2'h1 && i_monitor_buffer_ownership == {i_nonsecure_state_flag, 1'h1}
      && !(i_hyp_enabled && (i_hyp_profiling_trap || i_fine_grain_trap_enable
      && i_hyp_fine_read_trap_bit)) |=> o_hit && !o_trap && !o_undef;
  endproperty
  a_kern_ok: assert property (p_kern_ok) else $error("kernel read refused");

  // reserved bits never carry anything, whatever the outcome
  property p_rsvd;
    @(posedge i_clk) disable iff (i_rst)
      o_hit |-> o_rdata[63:20] == 44'h0 && o_rdata[7:6] == 2'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");

  // style, source and granularity bits of a returned value
  property p_fields;
    @(posedge i_clk) disable iff (i_rst)
      o_hit && !o_undef && !o_trap |-> o_rdata[5:3] == 3'h2 && o_rdata[19:16] == 4'h2;
  endproperty
  a_fields: assert property (p_fields) else $error("feature fields wrong");

  // reset clears every output by the following edge
  property p_reset;
    @(posedge i_clk)
      i_rst |=> !o_hit && !o_undef && !o_trap && o_rdata == 64'h0 && o_trap_class == 6'h0;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");

endmodule : psf_feature_reg

// *** test/psf_core_model.sv ***
// core-side model that issues system-register reads and writes
`timescale 1ns/1ps

module psf_core_model (
  output logic        o_req,   // access request pulse
  output logic        o_write, // access is a write
  output logic [15:0] o_enc,   // op0, op1, crn, crm, op2
  output logic [1:0]  o_el,    // exception level
  output logic [6:0]  o_state  // hyp, fgt, fine, tpms, own[1:0], ns
);
  initial {o_req, o_write, o_enc, o_el, o_state} = '0;

  // called just after a rising edge; non-blocking so the design samples it next edge
  task automatic drive(input logic req, input logic wr, input logic [15:0] enc,
                       input logic [1:0] el, input logic [6:0] st);
    o_req   <= req;
    o_write <= wr;
    o_enc   <= enc;
    o_el    <= el;
    o_state <= st;
  endtask : drive
endmodule : psf_core_model

// *** test/tb.sv ***
// self-checking bench for the profiling sampler feature register
`timescale 1ns/1ps

module tb;
  import psf_pkg::*;
  localparam logic [15:0] ENC_OK = {2'h3, 3'h0, 4'h9, 4'h9, 3'h7};
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        req, wr, o_hit, o_undef, o_trap;
  logic [15:0] enc;
  logic [1:0]  el, o_trap_el;
  logic [6:0]  st;
  logic [5:0]  o_trap_class;
  logic [63:0] o_rdata;
  int          err_total = 0;
  int          samples_checked = 0;
  int          seed = 42313;
  logic        pend_hit, nxt_hit;
  logic [9:0]  pend_st, nxt_st;

  always #2.5 i_clk = ~i_clk;

  psf_core_model i_psf_core_model (.o_req(req), .o_write(wr), .o_enc(enc), .o_el(el),
                                   .o_state(st));
  psf_feature_reg i_psf_feature_reg (
    .i_clk(i_clk), .i_rst(i_rst), .i_req(req), .i_write(wr),
    .i_op0(enc[15:14]), .i_op1(enc[13:11]), .i_crn(enc[10:7]), .i_crm(enc[6:3]),
    .i_op2(enc[2:0]), .i_el(el), .i_hyp_enabled(st[6]), .i_fine_grain_trap_enable(st[5]),
    .i_hyp_fine_read_trap_bit(st[4]), .i_hyp_profiling_trap(st[3]),
    .i_monitor_buffer_ownership(st[2:1]), .i_nonsecure_state_flag(st[0]),
    .o_hit(o_hit), .o_rdata(o_rdata), .o_undef(o_undef), .o_trap(o_trap),
    .o_trap_el(o_trap_el), .o_trap_class(o_trap_class));

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // status packed as undef, trap, target level, syndrome class
  function automatic logic [9:0] exp_status(input logic [1:0] lvl, input logic [6:0] s);
    logic own_bad;
    own_bad = s[0] ? (s[2:1] != 2'h3) : (s[2:1] != 2'h1);
    if (lvl == 2'h0) return {2'h2, 2'h0, 6'h00};
    if (lvl == 2'h1 && s[6] && ((s[5] && s[4]) || s[3])) return {2'h1, 2'h2, 6'h18};
    if (lvl != 2'h3 && own_bad) return {2'h1, 2'h3, 6'h18};
    return 10'h000;
  endfunction : exp_status

  task automatic compare_out(input logic hit, input logic [9:0] s);
    logic [63:0] d;
    logic [9:0]  so;
    d = (hit && s == 10'h000) ? {44'h0, 4'h2, 4'h6, 4'h4, 2'h0, 6'h17} : 64'h0;
    so = {o_undef, o_trap, o_trap_el, o_trap_class};
    check({63'h0, o_hit}, {63'h0, hit});
    check({54'h0, so}, {54'h0, s});
    check({60'h0, o_rdata[19:16]}, {60'h0, d[19:16]});
    check({60'h0, o_rdata[15:12]}, {60'h0, d[15:12]});
    check({60'h0, o_rdata[11:8]}, {60'h0, d[11:8]});
    check({63'h0, o_rdata[5]}, {63'h0, d[5]});
    check({62'h0, o_rdata[4:3]}, {62'h0, d[4:3]});
    check({61'h0, o_rdata[2:0]}, {61'h0, d[2:0]});
    check(o_rdata, d);
  endtask : compare_out

  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    logic r, w;
    logic [15:0] e;
    repeat (9) @(posedge i_clk);
    #1 compare_out(1'b0, 10'h000);
    @(posedge i_clk) i_rst <= 1'b0;
    pend_hit = 1'b0;
    pend_st = 10'h000;
    $display("test reset done");
    // random traffic every cycle, so back-to-back reads are common
    for (int n = 0; n < 600; n++) begin
      r = ($random(seed) & 3) != 0;
      w = ($random(seed) & 7) == 0;
      e = (($random(seed) & 7) == 0) ? ENC_OK ^ (16'h1 << ($random(seed) & 15)) : ENC_OK;
      if (n < 4) begin
        // writes with a good encoding at random levels are ignored
        r = 1'b1;
        w = 1'b1;
        e = ENC_OK;
      end
      if (n == 302) begin
        // the first request after reset waits one cycle with reset low
        r = 1'h0;
      end
      @(posedge i_clk);
      // a second reset in mid-run drops whatever request it meets
      i_rst <= (n == 300 || n == 301);
      i_psf_core_model.drive(r, w, e, n[1:0] ^ 2'($random(seed)), 7'($random(seed)));
      #1;
      nxt_hit = !i_rst && req && !wr && enc === ENC_OK;
      nxt_st = nxt_hit ? exp_status(el, st) : 10'h000;
      compare_out(pend_hit, pend_st);
      pend_hit = nxt_hit;
      pend_st = nxt_st;
      if (n == 303) begin
        $display("test mid-run reset done");
      end
    end
    $display("test random done");
    end_sim();
  end
endmodule : tb
